/* File: fpx_pkg.sv */
// fpx_pkg: shared constants, operation codes and carrier structs
package fpx_pkg;

  localparam int          BANK_WORDS   = 32;
  localparam logic [31:0] BANK_RESET   = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam int          FLAG_MSB     = 31;
  localparam int          FLAG_LSB     = 28;
  localparam int          SIGN_POS     = 31;
  localparam logic [7:0]  EXP_ZERO     = 8'h00;
  localparam logic [7:0]  EXP_MAX      = 8'hff;
  localparam logic [9:0]  EXP_BIAS     = 10'h07f;

  typedef enum logic [3:0] {
    FPX_MOVE_REG     = 4'h0,
    FPX_DHALF_TO_CORE = 4'h1,
    FPX_SREG_TO_CORE = 4'h2,
    FPX_CORE_TO_SREG = 4'h3,
    FPX_PAIR_TO_CORE = 4'h4,
    FPX_CORE_TO_PAIR = 4'h5,
    FPX_CORE_TO_DHALF = 4'h6,
    FPX_STATUS_READ  = 4'h7,
    FPX_STATUS_FLAGS = 4'h8,
    FPX_STATUS_WRITE = 4'h9,
    FPX_MULTIPLY     = 4'ha,
    FPX_NEGATE       = 4'hb,
    FPX_NEG_MUL_ACC  = 4'hc,
    FPX_NEG_MUL_SUB  = 4'hd,
    FPX_NEG_MULTIPLY = 4'he,
    FPX_LIST_POP     = 4'hf
  } fpx_op_type;

  typedef enum logic [1:0] {
    FPX_IDLE = 2'b01,
    FPX_POP  = 2'b10
  } fpx_state_type;

  typedef struct packed {
    logic              valid;
    logic              cond_pass;
    fpx_op_type        op;
    logic              dbl;
    logic              half;
    logic              dest_omitted;
    logic [4:0]        dest;
    logic [4:0]        src_a;
    logic [4:0]        src_b;
    logic [4:0]        count;
    logic [3:0]        core_first_idx;
    logic [3:0]        core_second_idx;
    logic [31:0]       core_first_data;
    logic [31:0]       core_second_data;
  } fpx_req_type;

  typedef struct packed {
    logic              first_valid;
    logic [3:0]        first_idx;
    logic [31:0]       first_data;
    logic              second_valid;
    logic [3:0]        second_idx;
    logic [31:0]       second_data;
  } fpx_core_wr_type;

  typedef struct packed {
    logic              valid;
    logic [3:0]        nzcv;
  } fpx_flags_type;

endpackage

/* File: fpx_sp_arith.sv */
// fpx_sp_arith: single-precision multiply and negated accumulate forms
module fpx_sp_arith (
  input  wire fpx_pkg::fpx_op_type op,
  input  wire logic [31:0]         opa,
  input  wire logic [31:0]         opb,
  input  wire logic [31:0]         acc,
  output logic [31:0]              result
);

  function automatic logic [31:0] fmul(input logic [31:0] x, input logic [31:0] y);
    logic [47:0] p;
    logic [9:0]  e;
    logic        s;
    s = x[31] ^ y[31];
    p = {1'b1, x[22:0]} * {1'b1, y[22:0]};
    e = {2'b00, x[30:23]} + {2'b00, y[30:23]} - fpx_pkg::EXP_BIAS;
    if (p[47]) begin
      e = e + 10'h001;
    end else begin
      p = p << 1;
    end
    if (x[30:23] == fpx_pkg::EXP_ZERO || y[30:23] == fpx_pkg::EXP_ZERO) begin
      fmul = {s, 31'h0};
    end else if (x[30:23] == fpx_pkg::EXP_MAX || y[30:23] == fpx_pkg::EXP_MAX) begin
      fmul = {s, fpx_pkg::EXP_MAX, 23'h0};
    end else if (e[9] || e == 10'h000) begin
      fmul = {s, 31'h0};
    end else if (e >= 10'h0ff) begin
      fmul = {s, fpx_pkg::EXP_MAX, 23'h0};
    end else begin
      fmul = {s, e[7:0], p[46:24]};
    end
  endfunction

  function automatic logic [31:0] fadd(input logic [31:0] x, input logic [31:0] y);
    logic [31:0] big;
    logic [31:0] sml;
    logic [26:0] mb;
    logic [26:0] ms;
    logic [26:0] sum;
    logic [9:0]  e;
    logic [7:0]  sh;
    big = (x[30:0] < y[30:0]) ? y : x;
    sml = (x[30:0] < y[30:0]) ? x : y;
    mb  = (big[30:23] == fpx_pkg::EXP_ZERO) ? 27'h0 : {2'b01, big[22:0], 2'b00};
    ms  = (sml[30:23] == fpx_pkg::EXP_ZERO) ? 27'h0 : {2'b01, sml[22:0], 2'b00};
    sh  = big[30:23] - sml[30:23];
    ms  = (sh > 8'h1a) ? 27'h0 : ms >> sh;
    sum = (big[31] == sml[31]) ? mb + ms : mb - ms;
    e   = {2'b00, big[30:23]};
    if (sum[26]) begin
      sum = sum >> 1;
      e   = e + 10'h001;
    end
    for (int i = 0; i < 26; i++) begin
      if (!sum[25] && sum != 27'h0) begin
        sum = sum << 1;
        e   = e - 10'h001;
      end
    end
    if (big[30:23] == fpx_pkg::EXP_MAX) begin
      fadd = big;
    end else if (sum == 27'h0 || e == 10'h000 || e[9]) begin
      fadd = 32'h0;
    end else if (e >= 10'h0ff) begin
      fadd = {big[31], fpx_pkg::EXP_MAX, 23'h0};
    end else begin
      fadd = {big[31], e[7:0], sum[24:2]};
    end
  endfunction

  wire logic [31:0] prod     = fmul(opa, opb);
  wire logic [31:0] neg_prod = {~prod[31], prod[30:0]};
  wire logic [31:0] neg_acc  = {~acc[31], acc[30:0]};

  always_comb begin
    unique case (op)
      fpx_pkg::FPX_NEG_MUL_ACC:  result = fadd(neg_acc, neg_prod);
      fpx_pkg::FPX_NEG_MUL_SUB:  result = fadd(neg_acc, prod);
      fpx_pkg::FPX_NEG_MULTIPLY: result = neg_prod;
      default:                   result = prod;
    endcase
  end

endmodule

/* File: fpx_exec.sv */
// fpx_exec: floating-point transfer and arithmetic execution unit
module fpx_exec (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire fpx_pkg::fpx_req_type  req,
  input  wire logic [31:0]           pop_word,
  input  wire logic                  pop_word_valid,
  input  wire logic [4:0]            bank_rd_idx,
  output fpx_pkg::fpx_core_wr_type   core_wr,
  output fpx_pkg::fpx_flags_type     flags_wr,
  output logic [31:0]                status_reg,
  output logic [31:0]                bank_rd_data,
  output logic                       pop_word_ready,
  output logic                       retired
);

  logic [31:0]            bank [fpx_pkg::BANK_WORDS];
  fpx_pkg::fpx_state_type state;
  fpx_pkg::fpx_state_type next_state;
  logic [4:0]             pop_ptr;
  logic [5:0]             pop_left;
  logic                   wr0_en;
  logic [4:0]             wr0_idx;
  logic [31:0]            wr0_data;
  logic                   wr1_en;
  logic [4:0]             wr1_idx;
  logic [31:0]            wr1_data;
  logic [31:0]            arith_result;

  // request decode
  wire logic take      = req.valid && state == fpx_pkg::FPX_IDLE;
  wire logic exec      = take && req.cond_pass;
  wire logic pop_go    = exec && req.op == fpx_pkg::FPX_LIST_POP && req.count != 5'h00;
  wire logic pop_take  = state == fpx_pkg::FPX_POP && pop_word_valid;
  wire logic pop_last  = pop_take && pop_left == 6'h01;

  wire logic [4:0] dst_lo  = {req.dest[3:0], 1'b0};
  wire logic [4:0] dst_hi  = {req.dest[3:0], 1'b1};
  wire logic [4:0] src_lo  = {req.src_a[3:0], 1'b0};
  wire logic [4:0] src_hi  = {req.src_a[3:0], 1'b1};
  wire logic [4:0] src_sel = {req.src_a[3:0], req.half};
  wire logic [4:0] dst_sel = {req.dest[3:0], req.half};
  wire logic [4:0] src_nxt = req.src_a + 5'h01;
  wire logic [4:0] dst_nxt = req.dest + 5'h01;
  wire logic       omit_ok = req.op == fpx_pkg::FPX_MULTIPLY
                          || req.op == fpx_pkg::FPX_NEG_MULTIPLY;
  wire logic [4:0] ar_dest = (omit_ok && req.dest_omitted) ? req.src_a : req.dest;

  wire logic [31:0] val_a   = bank[req.src_a];
  wire logic [31:0] val_nxt = bank[src_nxt];
  wire logic [31:0] neg_a   = {~val_a[fpx_pkg::SIGN_POS], val_a[30:0]};

  fpx_sp_arith u_arith (
    .op     (req.op),
    .opa    (val_a),
    .opb    (bank[req.src_b]),
    .acc    (bank[ar_dest]),
    .result (arith_result)
  );

  always_comb begin
    wr0_en   = 1'b0;
    wr0_idx  = req.dest;
    wr0_data = req.core_first_data;
    wr1_en   = 1'b0;
    wr1_idx  = dst_nxt;
    wr1_data = req.core_second_data;
    if (state == fpx_pkg::FPX_POP) begin
      wr0_en   = pop_take;
      wr0_idx  = pop_ptr;
      wr0_data = pop_word;
    end else if (exec) begin
      unique case (req.op)
        fpx_pkg::FPX_MOVE_REG: begin
          wr0_en   = 1'b1;
          wr0_idx  = req.dbl ? dst_lo : req.dest;
          wr0_data = req.dbl ? bank[src_lo] : val_a;
          wr1_en   = req.dbl;
          wr1_idx  = dst_hi;
          wr1_data = bank[src_hi];
        end
        fpx_pkg::FPX_CORE_TO_SREG: wr0_en = 1'b1;
        fpx_pkg::FPX_CORE_TO_PAIR: begin
          wr0_en = 1'b1;
          wr1_en = 1'b1;
        end
        fpx_pkg::FPX_CORE_TO_DHALF: begin
          wr0_en  = 1'b1;
          wr0_idx = dst_sel;
        end
        fpx_pkg::FPX_MULTIPLY, fpx_pkg::FPX_NEG_MUL_ACC,
        fpx_pkg::FPX_NEG_MUL_SUB, fpx_pkg::FPX_NEG_MULTIPLY: begin
          wr0_en   = 1'b1;
          wr0_idx  = ar_dest;
          wr0_data = arith_result;
        end
        fpx_pkg::FPX_NEGATE: begin
          wr0_en   = 1'b1;
          wr0_data = neg_a;
        end
        default: wr0_en = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < fpx_pkg::BANK_WORDS; i++) begin
        bank[i] <= fpx_pkg::BANK_RESET;
      end
    end else begin
      if (wr0_en) begin
        bank[wr0_idx] <= wr0_data;
      end
      if (wr1_en) begin
        bank[wr1_idx] <= wr1_data;
      end
    end
  end

  // core-side results
  wire logic to_core1 = exec && (req.op == fpx_pkg::FPX_DHALF_TO_CORE
                              || req.op == fpx_pkg::FPX_SREG_TO_CORE
                              || req.op == fpx_pkg::FPX_PAIR_TO_CORE
                              || req.op == fpx_pkg::FPX_STATUS_READ);
  wire logic to_core2 = exec && req.op == fpx_pkg::FPX_PAIR_TO_CORE;
  logic [31:0] core1_data;
  always_comb begin
    unique case (req.op)
      fpx_pkg::FPX_DHALF_TO_CORE: core1_data = bank[src_sel];
      fpx_pkg::FPX_STATUS_READ:   core1_data = status_reg;
      default:                    core1_data = val_a;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_wr  <= '0;
      flags_wr <= '0;
    end else begin
      core_wr.first_valid  <= to_core1;
      core_wr.first_idx    <= req.core_first_idx;
      core_wr.first_data   <= core1_data;
      core_wr.second_valid <= to_core2;
      core_wr.second_idx   <= req.core_second_idx;
      core_wr.second_data  <= val_nxt;
      flags_wr.valid       <= exec && req.op == fpx_pkg::FPX_STATUS_FLAGS;
      flags_wr.nzcv        <= status_reg[fpx_pkg::FLAG_MSB:fpx_pkg::FLAG_LSB];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= fpx_pkg::STATUS_RESET;
    end else if (exec && req.op == fpx_pkg::FPX_STATUS_WRITE) begin
      status_reg <= req.core_first_data;
    end
  end

  // pop sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      fpx_pkg::FPX_IDLE: if (pop_go) next_state = fpx_pkg::FPX_POP;
      fpx_pkg::FPX_POP:  if (pop_last) next_state = fpx_pkg::FPX_IDLE;
      default:           next_state = fpx_pkg::FPX_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state          <= fpx_pkg::FPX_IDLE;
      pop_ptr        <= 5'h00;
      pop_left       <= 6'h00;
      pop_word_ready <= 1'b0;
      retired        <= 1'b0;
      bank_rd_data   <= fpx_pkg::BANK_RESET;
    end else begin
      state          <= next_state;
      pop_word_ready <= next_state == fpx_pkg::FPX_POP;
      retired        <= (take && !pop_go) || pop_last;
      bank_rd_data   <= bank[bank_rd_idx];
      if (pop_go) begin
        pop_ptr  <= req.dbl ? dst_lo : req.dest;
        pop_left <= req.dbl ? {req.count, 1'b0} : {1'b0, req.count};
      end else if (pop_take) begin
        pop_ptr  <= pop_ptr + 5'h01;
        pop_left <= pop_left - 6'h01;
      end
    end
  end

  // checking helpers
  fpx_pkg::fpx_req_type h_req;
  logic                 h_exec;
  logic [31:0]          h_a;
  logic [31:0]          h_nxt;
  logic [31:0]          h_sel;
  logic [31:0]          h_keep;
  logic [31:0]          h_status;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      h_req    <= '0;
      h_exec   <= 1'b0;
      h_a      <= 32'h0;
      h_nxt    <= 32'h0;
      h_sel    <= 32'h0;
      h_keep   <= 32'h0;
      h_status <= 32'h0;
    end else begin
      h_req    <= req;
      h_exec   <= exec;
      h_a      <= val_a;
      h_nxt    <= val_nxt;
      h_sel    <= bank[src_sel];
      h_keep   <= bank[{req.dest[3:0], ~req.half}];
      h_status <= status_reg;
    end
  end

  property p_move_reg;
    @(posedge clk) disable iff (!reset_n)
      h_exec && h_req.op == fpx_pkg::FPX_MOVE_REG && !h_req.dbl
      |-> bank[h_req.dest] == h_a;
  endproperty
  a_move_reg: assert property (p_move_reg)
    else $error("register move altered value");

  property p_dhalf_out;
    @(posedge clk) disable iff (!reset_n)
      h_exec && h_req.op == fpx_pkg::FPX_DHALF_TO_CORE
      |-> core_wr.first_valid && core_wr.first_data == h_sel;
  endproperty
  a_dhalf_out: assert property (p_dhalf_out)
    else $error("wrong double half to core");

  property p_pair_out;
    @(posedge clk) disable iff (!reset_n)
      h_exec && h_req.op == fpx_pkg::FPX_PAIR_TO_CORE
      |-> core_wr.second_valid && core_wr.second_data == h_nxt
          && core_wr.first_data == h_a;
  endproperty
  a_pair_out: assert property (p_pair_out)
    else $error("pair transfer mismatch");

  property p_dhalf_in;
    @(posedge clk) disable iff (!reset_n)
      h_exec && h_req.op == fpx_pkg::FPX_CORE_TO_DHALF
      |-> bank[{h_req.dest[3:0], h_req.half}] == h_req.core_first_data
          && bank[{h_req.dest[3:0], ~h_req.half}] == h_keep;
  endproperty
  a_dhalf_in: assert property (p_dhalf_in)
    else $error("double half write wrong");

  property p_status_read;
    @(posedge clk) disable iff (!reset_n)
      exec && req.op == fpx_pkg::FPX_STATUS_READ
      |=> core_wr.first_valid && core_wr.first_data == $past(status_reg);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read mismatch");

  property p_flags;
    @(posedge clk) disable iff (!reset_n)
      h_exec && h_req.op == fpx_pkg::FPX_STATUS_FLAGS
      |-> flags_wr.valid && flags_wr.nzcv == h_status[31:28] && !core_wr.first_valid;
  endproperty
  a_flags: assert property (p_flags)
    else $error("flag copy mismatch");

  property p_status_write;
    @(posedge clk) disable iff (!reset_n)
      h_exec && h_req.op == fpx_pkg::FPX_STATUS_WRITE
      |-> status_reg == h_req.core_first_data;
  endproperty
  a_status_write: assert property (p_status_write)
    else $error("status write lost");

  property p_negate;
    @(posedge clk) disable iff (!reset_n)
      h_exec && h_req.op == fpx_pkg::FPX_NEGATE
      |-> bank[h_req.dest] == {~h_a[31], h_a[30:0]};
  endproperty
  a_negate: assert property (p_negate)
    else $error("negate result wrong");

  property p_cond_fail;
    @(posedge clk) disable iff (!reset_n)
      take && !req.cond_pass
      |=> !core_wr.first_valid && !flags_wr.valid && $stable(status_reg) && retired;
  endproperty
  a_cond_fail: assert property (p_cond_fail)
    else $error("failed condition had effect");

  property p_pop_word;
    @(posedge clk) disable iff (!reset_n)
      pop_take ##1 pop_word_ready && pop_word_valid
      |-> pop_ptr == $past(pop_ptr) + 5'h01;
  endproperty
  a_pop_word: assert property (p_pop_word)
    else $error("pop pointer not advancing");

endmodule

/* File: fpx_core_model.sv */
// fpx_core_model: integer core register file and flags facing the unit
module fpx_core_model (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire fpx_pkg::fpx_core_wr_type core_wr,
  input  wire fpx_pkg::fpx_flags_type   flags_wr,
  input  wire logic [3:0]               rd_a_idx,
  input  wire logic [3:0]               rd_b_idx,
  output logic [31:0]                   rd_a_data,
  output logic [31:0]                   rd_b_data,
  output logic [3:0]                    nzcv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] regs [16];

  // forwarding so back-to-back requests see fresh values
  function automatic logic [31:0] fwd(input logic [3:0] i);
    if (core_wr.second_valid && core_wr.second_idx == i) return core_wr.second_data;
    if (core_wr.first_valid && core_wr.first_idx == i) return core_wr.first_data;
    return regs[i];
  endfunction

  always_comb begin
    rd_a_data = fwd(rd_a_idx);
    rd_b_data = fwd(rd_b_idx);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 16; i++) regs[i] <= 32'h0;
      nzcv <= 4'h0;
    end else begin
      if (core_wr.first_valid) regs[core_wr.first_idx] <= core_wr.first_data;
      if (core_wr.second_valid) regs[core_wr.second_idx] <= core_wr.second_data;
      if (flags_wr.valid) nzcv <= flags_wr.nzcv;
    end
  end
endmodule

/* File: test_fpx_exec.sv */
// test_fpx_exec: self-checking bench for the execution unit
module test_fpx_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk, reset_n, pop_word_valid, pop_word_ready, retired;
  fpx_pkg::fpx_req_type     req, rb;
  fpx_pkg::fpx_core_wr_type core_wr;
  fpx_pkg::fpx_flags_type   flags_wr;
  logic [31:0]              pop_word, status_reg, bank_rd_data, core_a, core_b, seed, es;
  logic [4:0]               bank_rd_idx;
  logic [3:0]               nzcv;
  logic [31:0]              eb [32];
  logic [31:0]              ec [16];
  int                       n_fail, num_checks;
  fpx_pkg::fpx_op_type      tops [11] = '{fpx_pkg::FPX_MOVE_REG, fpx_pkg::FPX_DHALF_TO_CORE,
    fpx_pkg::FPX_SREG_TO_CORE, fpx_pkg::FPX_CORE_TO_SREG, fpx_pkg::FPX_PAIR_TO_CORE,
    fpx_pkg::FPX_CORE_TO_PAIR, fpx_pkg::FPX_CORE_TO_DHALF, fpx_pkg::FPX_STATUS_WRITE,
    fpx_pkg::FPX_STATUS_READ, fpx_pkg::FPX_STATUS_FLAGS, fpx_pkg::FPX_NEGATE};
  fpx_pkg::fpx_op_type      aops [5] = '{fpx_pkg::FPX_MULTIPLY, fpx_pkg::FPX_NEG_MUL_ACC,
    fpx_pkg::FPX_NEG_MUL_SUB, fpx_pkg::FPX_NEG_MULTIPLY, fpx_pkg::FPX_NEGATE};

  always_comb begin
    req = rb;
    req.core_first_data = core_a;
    req.core_second_data = core_b;
  end

  fpx_exec i_dut (.clk(clk), .reset_n(reset_n), .req(req), .pop_word(pop_word),
    .pop_word_valid(pop_word_valid), .bank_rd_idx(bank_rd_idx), .core_wr(core_wr),
    .flags_wr(flags_wr), .status_reg(status_reg), .bank_rd_data(bank_rd_data),
    .pop_word_ready(pop_word_ready), .retired(retired));
  fpx_core_model i_core (.clk(clk), .reset_n(reset_n), .core_wr(core_wr),
    .flags_wr(flags_wr), .rd_a_idx(rb.core_first_idx), .rd_b_idx(rb.core_second_idx),
    .rd_a_data(core_a), .rd_b_data(core_b), .nzcv(nzcv));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] fp(input shortreal r);
    return $shortrealtobits(r);
  endfunction
  function automatic shortreal fv(input logic [31:0] w);
    return $bitstoshortreal(w);
  endfunction
  function automatic logic [79:0] wv(input fpx_pkg::fpx_core_wr_type w);
    return 80'({w.first_valid, w.first_valid ? {w.first_idx, w.first_data} : 36'h0,
      w.second_valid, w.second_valid ? {w.second_idx, w.second_data} : 36'h0});
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bus(input string nm, input logic [79:0] e, input logic [79:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cw(inout fpx_pkg::fpx_core_wr_type w, input bit s, input logic [3:0] c,
                    input logic [31:0] v);
    if (s) {w.second_valid, w.second_idx, w.second_data} = {1'b1, c, v};
    else {w.first_valid, w.first_idx, w.first_data} = {1'b1, c, v};
    ec[c] = v;
  endtask
  task automatic idle();
    rb.valid = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic do_op(input fpx_pkg::fpx_op_type op, input logic [4:0] d, a, b,
                       input logic h, dbl, om, cp, input logic [3:0] c1, c2);
    fpx_pkg::fpx_core_wr_type ew;
    logic [4:0]               dd;
    logic [31:0]              p;
    logic [4:0]               x;
    rb = '0;
    {rb.valid, rb.cond_pass, rb.dbl, rb.half, rb.dest_omitted} = {1'b1, cp, dbl, h, om};
    rb.op = op;
    {rb.dest, rb.src_a, rb.src_b, rb.core_first_idx, rb.core_second_idx} = {d, a, b, c1, c2};
    ew = '0;
    dd = om ? a : d;
    x = {d[3:0], h};
    p = fp(fv(eb[a]) * fv(eb[b]));
    if (cp) case (op)
      fpx_pkg::FPX_MOVE_REG: if (dbl) begin
        eb[{d[3:0], 1'b0}] = eb[{a[3:0], 1'b0}];
        eb[{d[3:0], 1'b1}] = eb[{a[3:0], 1'b1}];
      end else eb[d] = eb[a];
      fpx_pkg::FPX_DHALF_TO_CORE: cw(ew, 0, c1, eb[{a[3:0], h}]);
      fpx_pkg::FPX_SREG_TO_CORE: cw(ew, 0, c1, eb[a]);
      fpx_pkg::FPX_CORE_TO_SREG: eb[d] = ec[c1];
      fpx_pkg::FPX_PAIR_TO_CORE: begin
        cw(ew, 0, c1, eb[a]);
        cw(ew, 1, c2, eb[a + 5'h1]);
      end
      fpx_pkg::FPX_CORE_TO_PAIR: {eb[d], eb[d + 5'h1]} = {ec[c1], ec[c2]};
      fpx_pkg::FPX_CORE_TO_DHALF: eb[x] = ec[c1];
      fpx_pkg::FPX_STATUS_READ: cw(ew, 0, c1, es);
      fpx_pkg::FPX_STATUS_WRITE: es = ec[c1];
      fpx_pkg::FPX_MULTIPLY: eb[dd] = p;
      fpx_pkg::FPX_NEGATE: eb[d] = eb[a] ^ 32'h8000_0000;
      fpx_pkg::FPX_NEG_MUL_ACC: eb[d] = fp(-fv(eb[d]) - fv(p));
      fpx_pkg::FPX_NEG_MUL_SUB: eb[d] = fp(-fv(eb[d]) + fv(p));
      fpx_pkg::FPX_NEG_MULTIPLY: eb[dd] = p ^ 32'h8000_0000;
      default: ;
    endcase
    @(posedge clk);
    #1;
    chk_bus("retired", 80'h1, 80'(retired));
    chk_bus("core_wr", wv(ew), wv(core_wr));
    chk_bus("flags_wr", 80'({cp && op == fpx_pkg::FPX_STATUS_FLAGS, es[31:28]}),
      80'({flags_wr.valid, flags_wr.valid ? flags_wr.nzcv : es[31:28]}));
    chk_word("status_reg", es, status_reg);
  endtask

  task automatic pop_list(input logic dbl, input logic [4:0] d, c, input bit flt);
    int          k, n;
    logic [31:0] w;
    rb = '0;
    {rb.valid, rb.cond_pass, rb.dbl, rb.dest, rb.count} = {2'b11, dbl, d, c};
    rb.op = fpx_pkg::FPX_LIST_POP;
    @(posedge clk);
    #1;
    rb.valid = 1'b0;
    for (k = 0; k < (dbl ? 2 * c : c); k++) begin
      w = flt ? fp(shortreal'(2 + xs() % 8)) : xs();
      if (flt && k >= 8) w = fp(shortreal'(xs() % 8) + 0.5);
      if (xs() % 3 == 0) begin
        {pop_word_valid, pop_word} = {1'b0, ~pop_word};
        @(posedge clk);
        #1;
      end
      {pop_word_valid, pop_word} = {1'b1, w};
      for (n = 0; pop_word_ready !== 1'b1 && n < 20; n++) begin
        @(posedge clk);
        #1;
      end
      if (n == 20) begin
        n_fail++;
        end_of_test();
      end
      eb[(dbl ? {d[3:0], 1'b0} : d) + 5'(k)] = w;
      @(posedge clk);
      #1;
    end
    chk_bus("pop_retired", 80'h1, 80'({pop_word_ready, retired}));
    {pop_word_valid, pop_word} = {1'b0, ~pop_word};
  endtask

  task automatic read_all(input string nm);
    idle();
    for (int k = 0; k < 32; k++) begin
      bank_rd_idx = 5'(k);
      @(posedge clk);
      #1;
      chk_word("bank_rd_data", eb[k], bank_rd_data);
    end
    $display("test %s done", nm);
  endtask

  initial begin
    {seed, n_fail, num_checks, reset_n, pop_word, pop_word_valid, bank_rd_idx} = {32'he0e9, 64'h0, 39'h0};
    rb = '0;
    es = fpx_pkg::STATUS_RESET;
    for (int k = 0; k < 32; k++) eb[k] = fpx_pkg::BANK_RESET;
    for (int k = 0; k < 16; k++) ec[k] = 32'h0;
    repeat (6) @(posedge clk);
    #1;
    reset_n = 1'b1;
    read_all("reset");
    pop_list(0, 5'd0, 5'd16, 1);
    pop_list(1, 5'd8, 5'd8, 0);
    pop_list(0, 5'd4, 5'd0, 0);
    read_all("pop");
    // core regs 0..14 only, never pc
    for (int k = 0; k < 15; k++) do_op(fpx_pkg::FPX_SREG_TO_CORE, 0, 5'(16 + k), 0, 0, 0, 0, 1, 4'(k), 0);
    do_op(fpx_pkg::FPX_CORE_TO_DHALF, 5'd9, 0, 0, 0, 0, 0, 1, 4'd3, 0);
    do_op(fpx_pkg::FPX_CORE_TO_DHALF, 5'd10, 0, 0, 1, 0, 0, 1, 4'd7, 0);
    do_op(fpx_pkg::FPX_DHALF_TO_CORE, 0, 5'd9, 0, 1, 0, 0, 1, 4'd1, 0);
    do_op(fpx_pkg::FPX_CORE_TO_PAIR, 5'd27, 0, 0, 0, 0, 0, 1, 4'd12, 4'd2);
    do_op(fpx_pkg::FPX_STATUS_WRITE, 0, 0, 0, 0, 0, 0, 0, 4'd5, 0);
    do_op(fpx_pkg::FPX_STATUS_WRITE, 0, 0, 0, 0, 0, 0, 1, 4'd5, 0);
    do_op(fpx_pkg::FPX_STATUS_READ, 0, 0, 0, 0, 0, 0, 1, 4'd14, 0);
    do_op(fpx_pkg::FPX_STATUS_FLAGS, 0, 0, 0, 0, 0, 0, 1, 0, 0);
    idle();
    chk_word("nzcv", 32'(es[31:28]), 32'(nzcv));
    read_all("directed");
    for (int k = 0; k < 80; k++) begin
      // core regs 0..12, pair singles consecutive
      do_op(tops[xs() % 11], (xs() % 2) ? 5'(16 + xs() % 15) : 5'(8 + xs() % 8),
        5'(xs() % 31), 0, xs() % 2, xs() % 2, 0, xs() % 8 != 0,
        4'(xs() % 13), 4'(xs() % 13));
    end
    read_all("random");
    // reload exact operands
    pop_list(0, 5'd0, 5'd16, 1);
    for (int k = 0; k < 30; k++) begin
      logic [4:0] ad;
      ad = 5'(16 + xs() % 16);
      do_op(fpx_pkg::FPX_MOVE_REG, ad, 5'(8 + xs() % 8), 0, 0, 0, 0, 1, 0, 0);
      do_op(aops[k % 5], ad, 5'(xs() % 8), 5'(xs() % 8), 0, 0,
        k >= 20, 1, 0, 0);
    end
    read_all("arith");
    end_of_test();
  end
endmodule
